/* File: hdlc_line_model.sv */
/* Serial line partner: sends frames as bit engine events.
   Assumes the bench calls send only between frames. */
module hdlc_line_model
(
   input wire logic                              aclk,
   output     hdlc_rx_status_pkg::frame_events_t events
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************
   // Frame sender
   // ****************
   initial events = '0;
   task automatic send(input int nb, input logic ab, input logic cg, input int ovf_at, input logic [31:0] gaps);
      hdlc_rx_status_pkg::frame_events_t ev;
      ev = '0;
      ev.frame_start = 1'b1;
      @(posedge aclk);
      events <= ev;
      for (int i = 0; i < nb; i++)
      begin
         ev = '0;
         ev.rx_bit_strobe = 1'b1;
         ev.rx_overflow_pulse = (i == ovf_at);
         // Slow line: idle cycle
         if (gaps[i % 32])
         begin
            @(posedge aclk);
            events <= '0;
         end
         @(posedge aclk);
         events <= ev;
      end
      ev = '0;
      ev.frame_close = !ab;
      ev.frame_abort = ab;
      ev.crc_pass = cg;
      @(posedge aclk);
      events <= ev;
      @(posedge aclk);
      events <= '0;
   endtask : send
endmodule : hdlc_line_model

/* File: hdlc_rx_frame_status_ch3.sv */
/*
 * Channel 3 receive frame status evaluation with AXI4-Lite registers.
 * Assumes the bit engine delivers frame events synchronous to aclk.
 */
module hdlc_rx_frame_status_ch3
#(
   parameter int CNT_W = 16
)
(
   input  wire logic                               aclk,
   input  wire logic                               aresetn,
   input  wire hdlc_rx_status_pkg::frame_events_t  events,
   output      hdlc_rx_status_pkg::frame_status_t  frame_status,
   output      logic                               status_strobe,
   output      logic                               overflow_irq,
   input  wire logic [7:0]                         awaddr,
   input  wire logic                               awvalid,
   output      logic                               awready,
   input  wire logic [31:0]                        wdata,
   input  wire logic [3:0]                         wstrb,
   input  wire logic                               wvalid,
   output      logic                               wready,
   output      logic [1:0]                         bresp,
   output      logic                               bvalid,
   input  wire logic                               bready,
   input  wire logic [7:0]                         araddr,
   input  wire logic                               arvalid,
   output      logic                               arready,
   output      logic [31:0]                        rdata,
   output      logic [1:0]                         rresp,
   output      logic                               rvalid,
   input  wire logic                               rready
);

   // ****************************************
   // Frame evaluation state
   // ****************************************
   hdlc_rx_status_pkg::frame_state_t  state;
   hdlc_rx_status_pkg::frame_state_t  next_state;
   logic [CNT_W-1:0]                  bit_count;
   logic [CNT_W-1:0]                  next_bit_count;
   logic                              overflow_seen;
   logic                              next_overflow_seen;
   hdlc_rx_status_pkg::frame_status_t next_frame_status;
   logic                              next_status_strobe;
   logic                              next_overflow_irq;
   logic [CNT_W-1:0]                  last_length;
   logic [CNT_W-1:0]                  next_last_length;
   logic                              report_flag;
   logic                              next_report_flag;
   hdlc_rx_status_pkg::ctrl_t         ctrl;
   logic [CNT_W-1:0]                  byte_count;
   logic [CNT_W-1:0]                  min_bytes;
   logic                              aligned;
   logic                              too_short;
   logic                              frame_end;
   logic                              status_read;

   assign byte_count = bit_count >> hdlc_rx_status_pkg::BYTE_SHIFT;
   assign frame_end  = (state == hdlc_rx_status_pkg::ST_RECEIVE)
                       && (events.frame_close || events.frame_abort);

   always_comb
   begin
      unique case (ctrl.addr_mode_sel_ch3)
         // RQ2 sixteen-bit minimum
         hdlc_rx_status_pkg::MODE_ADDR16:
            min_bytes = ctrl.rx_crc_option_ch3 ? CNT_W'(hdlc_rx_status_pkg::MIN16_CRC)
                                               : CNT_W'(hdlc_rx_status_pkg::MIN16_NO_CRC);
         // RQ3 eight-bit minimum
         hdlc_rx_status_pkg::MODE_ADDR8:
            min_bytes = ctrl.rx_crc_option_ch3 ? CNT_W'(hdlc_rx_status_pkg::MIN8_CRC)
                                               : CNT_W'(hdlc_rx_status_pkg::MIN8_NO_CRC);
         default:
            min_bytes = CNT_W'(hdlc_rx_status_pkg::MIN_OTHER);
      endcase
   end

   // RQ1 whole byte check
   assign aligned   = (bit_count % CNT_W'(hdlc_rx_status_pkg::BITS_PER_BYTE)) == '0;
   assign too_short = byte_count < min_bytes;

   always_comb
   begin
      next_state         = state;
      next_bit_count     = bit_count;
      next_overflow_seen = overflow_seen;
      next_frame_status  = frame_status;
      next_status_strobe = 1'b0;
      next_overflow_irq  = 1'b0;
      next_last_length   = last_length;
      next_report_flag   = report_flag && !status_read;
      unique case (state)
         hdlc_rx_status_pkg::ST_IDLE:
         begin
            if (events.frame_start)
            begin
               next_state         = hdlc_rx_status_pkg::ST_RECEIVE;
               next_bit_count     = '0;
               next_overflow_seen = 1'b0;
            end
         end
         hdlc_rx_status_pkg::ST_RECEIVE:
         begin
            if (events.rx_bit_strobe && bit_count != '1)
            begin
               next_bit_count = bit_count + CNT_W'(1);
            end
            if (events.rx_overflow_pulse)
            begin
               next_overflow_seen = 1'b1;
            end
            if (frame_end)
            begin
               next_state = hdlc_rx_status_pkg::ST_IDLE;
               // RQ4 suppress short frames
               if (!too_short)
               begin
                  // RQ7 validity bit
                  next_frame_status.frame_valid_flag_ch3 = aligned;
                  // RQ5 overflow bit
                  next_frame_status.rx_overflow_flag_ch3 = overflow_seen || events.rx_overflow_pulse;
                  // RQ6 CRC result
                  next_frame_status.crc_ok_flag_ch3      = events.crc_pass;
                  // RQ8 abort bit
                  next_frame_status.rx_aborted_flag_ch3  = events.frame_abort;
                  next_status_strobe = 1'b1;
                  next_last_length   = bit_count;
                  // Set wins over read clear
                  next_report_flag   = 1'b1;
                  // RQ5 maskable interrupt
                  next_overflow_irq  = (overflow_seen || events.rx_overflow_pulse)
                                       && !ctrl.overflow_irq_mask;
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state         <= hdlc_rx_status_pkg::ST_IDLE;
         bit_count     <= '0;
         overflow_seen <= 1'b0;
         frame_status  <= hdlc_rx_status_pkg::STATUS_RESET;
         status_strobe <= 1'b0;
         overflow_irq  <= 1'b0;
         last_length   <= '0;
         report_flag   <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         bit_count     <= next_bit_count;
         overflow_seen <= next_overflow_seen;
         frame_status  <= next_frame_status;
         status_strobe <= next_status_strobe;
         overflow_irq  <= next_overflow_irq;
         last_length   <= next_last_length;
         report_flag   <= next_report_flag;
      end
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   logic                      aw_held;
   logic                      next_aw_held;
   logic [7:0]                aw_addr;
   logic [7:0]                next_aw_addr;
   logic                      w_held;
   logic                      next_w_held;
   logic [31:0]               w_data;
   logic [31:0]               next_w_data;
   logic [3:0]                w_strb;
   logic [3:0]                next_w_strb;
   logic                      next_bvalid;
   logic [1:0]                next_bresp;
   logic                      next_awready;
   logic                      next_wready;
   logic                      next_arready;
   logic                      next_rvalid;
   logic [31:0]               next_rdata;
   logic [1:0]                next_rresp;
   hdlc_rx_status_pkg::ctrl_t next_ctrl;
   logic                      do_write;
   logic                      ar_take;

   assign do_write    = aw_held && w_held && !bvalid;
   assign ar_take     = arvalid && arready;
   assign status_read = ar_take && araddr == hdlc_rx_status_pkg::STATUS_OFFSET;

   always_comb
   begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid && !bready;
      next_bresp   = bresp;
      next_ctrl    = ctrl;
      next_rvalid  = rvalid && !rready;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_held = 1'b1;
         next_w_data = wdata;
         next_w_strb = wstrb;
      end
      if (do_write)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = hdlc_rx_status_pkg::RESP_OKAY;
         unique case (aw_addr)
            hdlc_rx_status_pkg::CTRL_OFFSET:
            begin
               if (w_strb[0])
               begin
                  next_ctrl = w_data[$bits(hdlc_rx_status_pkg::ctrl_t)-1:0];
               end
            end
            hdlc_rx_status_pkg::STATUS_OFFSET,
            hdlc_rx_status_pkg::LENGTH_OFFSET:
            begin
               next_bresp = hdlc_rx_status_pkg::RESP_OKAY;
            end
            default:
               next_bresp = hdlc_rx_status_pkg::RESP_DECERR;
         endcase
      end
      if (ar_take)
      begin
         next_rvalid = 1'b1;
         next_rdata  = '0;
         next_rresp  = hdlc_rx_status_pkg::RESP_OKAY;
         unique case (araddr)
            hdlc_rx_status_pkg::CTRL_OFFSET:
               next_rdata[$bits(hdlc_rx_status_pkg::ctrl_t)-1:0] = ctrl;
            hdlc_rx_status_pkg::STATUS_OFFSET:
            begin
               next_rdata[$bits(hdlc_rx_status_pkg::frame_status_t)-1:0] = frame_status;
               next_rdata[hdlc_rx_status_pkg::REPORT_BIT]                = report_flag;
            end
            hdlc_rx_status_pkg::LENGTH_OFFSET:
               next_rdata[CNT_W-1:0] = last_length;
            default:
               next_rresp = hdlc_rx_status_pkg::RESP_DECERR;
         endcase
      end
      next_awready = !next_aw_held;
      next_wready  = !next_w_held;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held  <= 1'b0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         bvalid  <= 1'b0;
         bresp   <= hdlc_rx_status_pkg::RESP_OKAY;
         awready <= 1'b0;
         wready  <= 1'b0;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= hdlc_rx_status_pkg::RESP_OKAY;
         ctrl    <= hdlc_rx_status_pkg::CTRL_RESET;
      end
      else
      begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held  <= next_w_held;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         awready <= next_awready;
         wready  <= next_wready;
         arready <= next_arready;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
         ctrl    <= next_ctrl;
      end
   end

endmodule : hdlc_rx_frame_status_ch3

/* File: hdlc_rx_status_pkg.sv */
/*
 * Constants, field layouts and carrier types of the channel 3 receive
 * frame status block. Assumes one 40 MHz clock and an AXI4-Lite master.
 */
// What this block does
// RQ1 - A frame whose bit length is not a multiple of eight is invalid.
// RQ2 - Sixteen-bit address mode: minimum 4 bytes without CRC option, 3 with it.
// RQ3 - Eight-bit address mode: minimum 3 bytes without CRC option, 2 with it.
// RQ4 - Frames below the applicable minimum length produce no status report.
// RQ5 - Overflow during the frame sets its status bit and a maskable interrupt.
// RQ6 - CRC result bit per frame: 0 check failed, 1 check passed.
// RQ7 - Validity bit per frame: 1 valid, 0 invalid.
// RQ8 - Aborted bit set when the frame ended in an abort sequence.
package hdlc_rx_status_pkg;

   // ****************************************
   // Register map and bus answers
   // ****************************************
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] LENGTH_OFFSET = 8'h08;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_DECERR   = 2'h3;
   localparam int         REPORT_BIT    = 8;

   // ****************************************
   // Modes and minimum lengths in bytes
   // ****************************************
   localparam logic [2:0] MODE_ADDR16     = 3'h3;
   localparam logic [2:0] MODE_ADDR8      = 3'h2;
   localparam int         MIN16_NO_CRC    = 4;
   localparam int         MIN16_CRC       = 3;
   localparam int         MIN8_NO_CRC     = 3;
   localparam int         MIN8_CRC        = 2;
   localparam int         MIN_OTHER       = 1;
   localparam int         BITS_PER_BYTE   = 8;
   localparam int         BYTE_SHIFT      = 3;

   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic       overflow_irq_mask;
      logic       rx_crc_option_ch3;
      logic [2:0] addr_mode_sel_ch3;
   } ctrl_t;

   typedef struct packed {
      logic frame_valid_flag_ch3;
      logic rx_overflow_flag_ch3;
      logic crc_ok_flag_ch3;
      logic rx_aborted_flag_ch3;
   } frame_status_t;

   typedef struct packed {
      logic frame_start;
      logic rx_bit_strobe;
      logic frame_close;
      logic frame_abort;
      logic rx_overflow_pulse;
      logic crc_pass;
   } frame_events_t;

   typedef enum logic [0:0] {
      ST_IDLE    = 1'b0,
      ST_RECEIVE = 1'b1
   } frame_state_t;

   localparam ctrl_t         CTRL_RESET   = 5'h00;
   localparam frame_status_t STATUS_RESET = 4'h0;

endpackage : hdlc_rx_status_pkg

/* File: hdlc_rx_status_sva.sv */
/* Port checker of the channel 3 frame status block.
   Assumes binding to hdlc_rx_frame_status_ch3 and one clock domain. */
module hdlc_rx_status_sva
#(
   parameter int CNT_W = 16
)
(
   input wire logic                              aclk,
   input wire logic                              aresetn,
   input wire hdlc_rx_status_pkg::frame_events_t events,
   input wire hdlc_rx_status_pkg::frame_status_t frame_status,
   input wire logic                              status_strobe,
   input wire logic                              overflow_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************
   // Frame tracking
   // ****************
   logic             in_frame, next_in_frame, ovf, next_ovf, ends;
   logic [CNT_W-1:0] bits, next_bits;
   assign ends = in_frame && (events.frame_close || events.frame_abort);
   always_comb
   begin
      next_in_frame = in_frame;
      next_bits = bits;
      next_ovf = ovf;
      if (!in_frame && events.frame_start)
      begin
         next_in_frame = 1'b1;
         next_bits = '0;
         next_ovf = 1'b0;
      end
      else if (ends)
         next_in_frame = 1'b0;
      else if (in_frame)
      begin
         if (events.rx_bit_strobe && !(&bits))
            next_bits = bits + 1'b1;
         if (events.rx_overflow_pulse)
            next_ovf = 1'b1;
      end
   end
   always_ff @(posedge aclk)
   begin
      in_frame <= aresetn ? next_in_frame : 1'b0;
      bits <= aresetn ? next_bits : '0;
      ovf <= aresetn ? next_ovf : 1'b0;
   end
   // ****************
   // Properties
   // ****************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_end;
      ends;
   endsequence
   sequence s_report;
      status_strobe;
   endsequence
   a_strobe_cause: assert property (s_report |-> $past(ends))
      else $error("strobe without frame end");
   a_short_silent: assert property (s_end ##0 (bits < 8) |=> !status_strobe)
      else $error("short frame reported");
   a_valid_align: assert property (s_report |-> frame_status.frame_valid_flag_ch3 == ($past(bits[2:0]) == 3'h0))
      else $error("validity wrong");
   a_long_report: assert property (s_end ##0 (bits >= 32) |=> s_report)
      else $error("long frame not reported");
   a_ovf_flag: assert property (s_report |-> frame_status.rx_overflow_flag_ch3 == $past(ovf || events.rx_overflow_pulse))
      else $error("overflow flag wrong");
   a_irq_report: assert property (overflow_irq |-> status_strobe && frame_status.rx_overflow_flag_ch3)
      else $error("interrupt without overflow report");
   a_crc_flag: assert property (s_report |-> frame_status.crc_ok_flag_ch3 == $past(events.crc_pass))
      else $error("crc flag wrong");
   a_abort_flag: assert property (s_report |-> frame_status.rx_aborted_flag_ch3 == $past(events.frame_abort))
      else $error("abort flag wrong");
   a_status_hold: assert property (!status_strobe |-> $stable(frame_status))
      else $error("status changed without report");
endmodule : hdlc_rx_status_sva

bind hdlc_rx_frame_status_ch3 hdlc_rx_status_sva #(.CNT_W(CNT_W)) i_sva (.aclk(aclk), .aresetn(aresetn),
   .events(events), .frame_status(frame_status), .status_strobe(status_strobe), .overflow_irq(overflow_irq));

/* File: tb_top.sv */
/* Self-checking bench of the channel 3 frame status block.
   Assumes the line model and a bus master task set in this module. */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, status_strobe, overflow_irq, capirq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, seed, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   hdlc_rx_status_pkg::frame_events_t events;
   hdlc_rx_status_pkg::frame_status_t frame_status, cap;
   int          error_cnt, samples_checked, nrep;
   logic [4:0]  exp_q[$];
   hdlc_rx_frame_status_ch3 #(.CNT_W(16)) i_dut (.aclk(aclk), .aresetn(aresetn), .events(events),
      .frame_status(frame_status), .status_strobe(status_strobe), .overflow_irq(overflow_irq),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   hdlc_line_model i_line (.aclk(aclk), .events(events));
   // ****************
   // Clock, monitor, helpers
   // ****************
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      if (status_strobe === 1'b1)
      begin
         nrep++;
         cap = frame_status;
         capirq = overflow_irq;
         if (exp_q.size() > 0)
            chk("queued report", exp_q.pop_front(), {overflow_irq, frame_status});
         else
            chk("queued report", 32'hFFFF_FFFF, {overflow_irq, frame_status});
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   function automatic int min_b(input logic [2:0] m, input logic c);
      if (m == hdlc_rx_status_pkg::MODE_ADDR16)
         return c ? 3 : 4;
      if (m == hdlc_rx_status_pkg::MODE_ADDR8)
         return c ? 2 : 3;
      return 1;
   endfunction : min_b
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      $display("mismatch watchdog expected end seen hang");
      summarize();
   end
   // ****************
   // Tests
   // ****************
   initial
   begin
      int b, mn, oa, m, len;
      logic [2:0] md;
      logic c, rep, ov;
      logic [3:0] e, pst;
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
      {error_cnt, samples_checked, nrep, len, pst} = '0;
      seed = 32'h58FC;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(hdlc_rx_status_pkg::CTRL_OFFSET);
      chk("ctrl reset", 32'h0, d);
      wr(8'h40, 32'hFF, 4'hF);
      chk("unmapped bresp", 2'h3, r);
      rd(8'h40);
      chk("unmapped rresp", 2'h3, r);
      wr(hdlc_rx_status_pkg::CTRL_OFFSET, 32'h1F, 4'hE);
      rd(hdlc_rx_status_pkg::CTRL_OFFSET);
      chk("ctrl no strobe", 32'h0, d);
      wr(hdlc_rx_status_pkg::STATUS_OFFSET, 32'hFFFF, 4'hF);
      chk("status wr bresp", hdlc_rx_status_pkg::RESP_OKAY, r);
      $display("bus test done");
      for (int k = 0; k < 18; k++)
      begin
         md = (k < 6) ? 3'h3 : (k < 12) ? 3'h2 : 3'h0;
         c = (k % 6) >= 3;
         mn = min_b(md, c);
         b = mn * 8 + ((k % 3 == 0) ? -8 : (k % 3 == 1) ? 0 : 3);
         seed = xs(seed);
         oa = seed[3] ? int'(seed[5:4]) : -1;
         ov = oa >= 0 && oa < b;
         wr(hdlc_rx_status_pkg::CTRL_OFFSET, {27'h0, seed[2], c, md}, 4'hF);
         chk("ctrl bresp", hdlc_rx_status_pkg::RESP_OKAY, r);
         m = nrep;
         rep = (b / 8) >= mn;
         e = {b % 8 == 0, ov, seed[1], seed[0]};
         if (rep)
            exp_q.push_back({ov && !seed[2], e});
         i_line.send(b, seed[0], seed[1], oa, seed);
         repeat (2) @(posedge aclk);
         chk("pending reports", 0, exp_q.size());
         chk("report count", rep, nrep - m);
         if (rep)
         begin
            pst = e;
            len = b;
            chk("frame status", e, cap);
            chk("overflow irq", ov && !seed[2], capirq);
         end
         rd(hdlc_rx_status_pkg::STATUS_OFFSET);
         chk("status reg", {23'h0, rep, 4'h0, pst}, d);
         chk("status rresp", hdlc_rx_status_pkg::RESP_OKAY, r);
         rd(hdlc_rx_status_pkg::LENGTH_OFFSET);
         chk("length reg", len, d);
         $display("frame test %0d done", k);
      end
      summarize();
   end
endmodule : tb_top
